// >>> shared/clock_source_control_pkg.sv
package clock_source_control_pkg;

    // register byte offsets on the apb bus
    localparam logic [7:0] ADDR_CLOCK_CONTROL_0  = 8'h00;
    localparam logic [7:0] ADDR_CLOCK_CONTROL_1  = 8'h04;
    localparam logic [7:0] ADDR_OSC_STOP_DETECT  = 8'h08;
    localparam logic [7:0] ADDR_PROCESSOR_MODE_2 = 8'h0C;
    localparam logic [7:0] ADDR_WRITE_PROTECT    = 8'h10;
    localparam logic [7:0] ADDR_PLL_CONTROL      = 8'h14;
    localparam logic [7:0] ADDR_CLOCK_STATUS     = 8'h18;

    // clock_control_0 fields
    localparam int CC0_PERIPH_STOP_IN_WAIT = 2;
    localparam int CC0_SUBOSC_DRIVE_HIGH   = 3;
    localparam int CC0_SUBOSC_PORT_SELECT  = 4;
    localparam int CC0_MAIN_OSC_STOP       = 5;
    localparam int CC0_DIV8_SELECT         = 6;
    localparam int CC0_SUB_CLOCK_SELECT    = 7;

    // clock_control_1 fields
    localparam int CC1_STOP_MODE_REQUEST   = 0;
    localparam int CC1_PLL_SELECT          = 1;
    localparam int CC1_MAIN_DRIVE_HIGH     = 5;
    localparam int CC1_DIV_RATIO_LOW       = 6;
    localparam int CC1_DIV_RATIO_HIGH      = 7;

    // osc_stop_detect_control fields
    localparam int OSD_DETECT_ENABLE       = 0;
    localparam int OSD_ONCHIP_OSC_SELECT   = 1;

    // processor_mode_2 fields
    localparam int PM2_CLOCK_CHANGE_LOCK   = 1;
    localparam int PM2_WDT_ONCHIP_SOURCE   = 2;

    // write_protect_register fields
    localparam int WP_CLK_REG_WRITE_UNLOCK = 0;
    localparam int WP_MODE_REG_WRITE_UNLOCK = 1;
    localparam logic [7:0] WP_WRITABLE_MASK = 8'h03;

    // pll_control fields
    localparam int PLL_ON                  = 7;
    localparam logic [7:0] PLL_RATIO_MASK  = 8'h07;

    // reset values
    localparam logic [7:0] RST_CLOCK_CONTROL_0  = 8'h48;
    localparam logic [7:0] RST_CLOCK_CONTROL_1  = 8'h20;
    localparam logic [7:0] RST_OSC_STOP_DETECT  = 8'h00;
    localparam logic [7:0] RST_PROCESSOR_MODE_2 = 8'h00;
    localparam logic [7:0] RST_WRITE_PROTECT    = 8'h00;
    localparam logic [7:0] RST_PLL_CONTROL      = 8'h02;

    // half period of the cpu clock in source transitions
    localparam logic [4:0] HALF_DIV1  = 5'h01;
    localparam logic [4:0] HALF_DIV2  = 5'h02;
    localparam logic [4:0] HALF_DIV4  = 5'h04;
    localparam logic [4:0] HALF_DIV8  = 5'h08;
    localparam logic [4:0] HALF_DIV16 = 5'h10;

    typedef enum logic [1:0] {
        SRC_MAIN,
        SRC_SUB,
        SRC_ONCHIP,
        SRC_PLL
    } clk_src_e;

    typedef enum logic [1:0] {
        PHASE_LOW,
        PHASE_HIGH,
        PHASE_HALTED
    } clk_phase_e;

endpackage

// >>> shared/clk_sel_if.sv
`timescale 1ns/1ps
`default_nettype none

interface clk_sel_if;
    import clock_source_control_pkg::*;

    clk_src_e   src;
    logic [4:0] half_count;
    logic       halt;
    clk_src_e   active_src;
    logic       running;

    modport ctl (
        output src,
        output half_count,
        output halt,
        input  active_src,
        input  running
    );

    modport div (
        input  src,
        input  half_count,
        input  halt,
        output active_src,
        output running
    );
endinterface

`default_nettype wire

// >>> logic/glitchless_clk_div.sv
`timescale 1ns/1ps
`default_nettype none

module glitchless_clk_div
    import clock_source_control_pkg::*;
(
    input  wire logic       sys_clk_i,
    input  wire logic       sys_rst_i,
    input  wire logic [3:0] src_clks_i,
    clk_sel_if.div          cfg,
    output var  logic       cpu_clk_o
);

    logic [3:0] src_prev_q;
    clk_src_e   src_q;
    logic [4:0] half_q;
    logic [4:0] cnt_q;
    clk_phase_e phase_q;
    logic       edge_seen;
    logic       phase_done;

    assign edge_seen  = src_clks_i[src_q] ^ src_prev_q[src_q];
    assign phase_done = edge_seen && ((cnt_q + 5'h01) == half_q);

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            src_prev_q <= 4'h0;
        end else begin
            src_prev_q <= src_clks_i;
        end
    end

    // source and ratio only change at the end of a low phase or on leaving the halted state, so no phase is cut short;
    // a source that has already died cannot finish its phase, software switches first
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            src_q     <= SRC_MAIN;
            half_q    <= HALF_DIV8;
            cnt_q     <= 5'h00;
            phase_q   <= PHASE_LOW;
            cpu_clk_o <= 1'b0;
        end else begin
            case (phase_q)
                PHASE_LOW: begin
                    if (phase_done) begin
                        cnt_q  <= 5'h00;
                        src_q  <= cfg.src;
                        half_q <= cfg.half_count;
                        if (cfg.halt) begin
                            phase_q <= PHASE_HALTED;
                        end else begin
                            phase_q   <= PHASE_HIGH;
                            cpu_clk_o <= 1'b1;
                        end
                    end else if (edge_seen) begin
                        cnt_q <= cnt_q + 5'h01;
                    end
                end
                PHASE_HIGH: begin
                    if (phase_done) begin
                        cnt_q     <= 5'h00;
                        phase_q   <= PHASE_LOW;
                        cpu_clk_o <= 1'b0;
                    end else if (edge_seen) begin
                        cnt_q <= cnt_q + 5'h01;
                    end
                end
                PHASE_HALTED: begin
                    cnt_q <= 5'h00;
                    if (!cfg.halt) begin
                        src_q   <= cfg.src;
                        half_q  <= cfg.half_count;
                        phase_q <= PHASE_LOW;
                    end
                end
                default: begin
                    phase_q   <= PHASE_LOW;
                    cpu_clk_o <= 1'b0;
                end
            endcase
        end
    end

    assign cfg.active_src = src_q;
    assign cfg.running    = (phase_q != PHASE_HALTED);

    a_no_short_phase: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        $changed(cpu_clk_o) |-> $past(phase_done))
        else $error("cpu clock toggled before its phase count completed");

    a_switch_when_low: assert property (@(posedge sys_clk_i) disable iff (sys_rst_i)
        ($changed(src_q) || $changed(half_q))
        |-> !$past(cpu_clk_o) && ($past(phase_done) || ($past(phase_q) == PHASE_HALTED)))
        else $error("clock source or ratio changed outside a low phase boundary");

endmodule

`default_nettype wire

// >>> logic/clock_source_control.sv
// Contract
// - clock control 0/1 writes ignored unless the write unlock bit is set
// - sub drive high forced to 1 while pins are ports or on stop entry
// - main oscillator stopped: output pin high, feedback resistor stays connected
// - stop entry from main or on-chip modes sets divide-by-8 select
// - clock change lock freezes peripheral stop, main stop and sub select bits
// - on-chip off and main stopped: divide-by-8 and main drive high held at 1
// - main drive high set on stop from main modes or main stop in low speed
// - division ratio field applies only while divide-by-8 select is 0
// - stop mode: main output high, feedback off, sub pins high impedance
// - clock change lock ignores writes to stop request and pll select
// - watchdog on-chip source ignores writes to the stop request
// - reset selects main clock divided by eight for the cpu
// - clock change lock cannot be cleared once set
// - reset leaves sub oscillator off with feedback disconnected
`timescale 1ns/1ps
`default_nettype none

module clock_source_control
    import clock_source_control_pkg::*;
(
    input  wire logic        sys_clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output var  logic [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic        main_clk_i,
    input  wire logic        sub_clk_i,
    input  wire logic        onchip_clk_i,
    input  wire logic        pll_clk_i,
    input  wire logic        wake_i,
    output var  logic        cpu_clk_o,
    output logic             stop_mode_o,
    output logic             main_osc_run_o,
    output logic             main_osc_output_high_o,
    output logic             main_feedback_on_o,
    output logic             main_drive_high_o,
    output logic             sub_osc_run_o,
    output logic             sub_feedback_on_o,
    output logic             sub_pins_hiz_o,
    output logic             subosc_drive_high_o,
    output logic             onchip_osc_run_o,
    output logic             pll_on_o,
    output logic             periph_stop_in_wait_o,
    output logic             osc_stop_detect_enable_o
);

    logic [7:0]  clock_control_0_q;
    logic [7:0]  clock_control_0_d;
    logic [7:0]  clock_control_1_q;
    logic [7:0]  clock_control_1_d;
    logic [7:0]  osc_stop_detect_control_q;
    logic [7:0]  processor_mode_2_q;
    logic [7:0]  write_protect_register_q;
    logic [7:0]  pll_control_q;
    logic [31:0] rdata_d;
    logic        addr_hit;
    logic        wr_en;
    logic        unlock;
    logic        lock;
    logic        wdt_src;
    logic        stop_entry;
    logic        main_mode;
    logic        main_stop_low_speed;
    logic        fixed_div8;
    logic [7:0]  w;

    clk_sel_if sel ();

    assign unlock  = write_protect_register_q[WP_CLK_REG_WRITE_UNLOCK];
    assign lock    = processor_mode_2_q[PM2_CLOCK_CHANGE_LOCK];
    assign wdt_src = processor_mode_2_q[PM2_WDT_ONCHIP_SOURCE];
    assign wr_en   = psel_i && penable_i && pwrite_i;

    // main modes: cpu runs from the main clock or the pll, neither sub nor on-chip selected
    assign main_mode = !clock_control_0_q[CC0_SUB_CLOCK_SELECT] && !osc_stop_detect_control_q[OSD_ONCHIP_OSC_SELECT];

    // an accepted write that raises the stop request
    assign stop_entry = wr_en && (paddr_i == ADDR_CLOCK_CONTROL_1) && unlock && !lock && !wdt_src
                        && pwdata_i[CC1_STOP_MODE_REQUEST] && !clock_control_1_q[CC1_STOP_MODE_REQUEST];

    assign fixed_div8 = !osc_stop_detect_control_q[OSD_ONCHIP_OSC_SELECT]
                        && clock_control_0_q[CC0_MAIN_OSC_STOP];

    // apb slave: zero wait states, unmapped offsets answer with an error
    always_comb begin
        addr_hit = 1'b1;
        rdata_d  = 32'h0000_0000;
        case (paddr_i)
            ADDR_CLOCK_CONTROL_0:  rdata_d[7:0] = clock_control_0_q;
            ADDR_CLOCK_CONTROL_1:  rdata_d[7:0] = clock_control_1_q;
            ADDR_OSC_STOP_DETECT:  rdata_d[7:0] = osc_stop_detect_control_q;
            ADDR_PROCESSOR_MODE_2: rdata_d[7:0] = processor_mode_2_q;
            ADDR_WRITE_PROTECT:    rdata_d[7:0] = write_protect_register_q;
            ADDR_PLL_CONTROL:      rdata_d[7:0] = pll_control_q;
            ADDR_CLOCK_STATUS:     rdata_d[3:0] = {sel.running, sel.active_src, stop_mode_o};
            default:               addr_hit = 1'b0;
        endcase
    end

    assign pready_o  = 1'b1;
    assign pslverr_o = psel_i && penable_i && !addr_hit;

    // read data captured in the setup cycle, stable for the access phase
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            prdata_o <= 32'h0000_0000;
        end else if (psel_i && !penable_i && !pwrite_i) begin
            prdata_o <= rdata_d;
        end
    end

    // clock_control_0 next value: software write, then hardware forcing on top
    always_comb begin
        clock_control_0_d = clock_control_0_q;
        w = pwdata_i[7:0];
        if (wr_en && (paddr_i == ADDR_CLOCK_CONTROL_0) && unlock) begin
            if (lock) begin
                w[CC0_PERIPH_STOP_IN_WAIT] = clock_control_0_q[CC0_PERIPH_STOP_IN_WAIT];
                w[CC0_MAIN_OSC_STOP]       = clock_control_0_q[CC0_MAIN_OSC_STOP];
                w[CC0_SUB_CLOCK_SELECT]    = clock_control_0_q[CC0_SUB_CLOCK_SELECT];
            end
            clock_control_0_d = w;
        end
        if (!clock_control_0_d[CC0_SUBOSC_PORT_SELECT] || stop_entry) begin
            clock_control_0_d[CC0_SUBOSC_DRIVE_HIGH] = 1'b1;
        end
        if (stop_entry && !clock_control_0_q[CC0_SUB_CLOCK_SELECT]) begin
            clock_control_0_d[CC0_DIV8_SELECT] = 1'b1;
        end
        if (fixed_div8) begin
            clock_control_0_d[CC0_DIV8_SELECT] = 1'b1;
        end
    end

    // main oscillator being stopped while the sub clock runs the cpu
    assign main_stop_low_speed = clock_control_0_d[CC0_MAIN_OSC_STOP] && !clock_control_0_q[CC0_MAIN_OSC_STOP]
                                 && clock_control_0_q[CC0_SUB_CLOCK_SELECT];

    always_comb begin
        clock_control_1_d = clock_control_1_q;
        if (wake_i) begin
            clock_control_1_d[CC1_STOP_MODE_REQUEST] = 1'b0;
        end
        if (wr_en && (paddr_i == ADDR_CLOCK_CONTROL_1) && unlock) begin
            clock_control_1_d = pwdata_i[7:0];
            if (lock || wdt_src) begin
                clock_control_1_d[CC1_STOP_MODE_REQUEST] = clock_control_1_q[CC1_STOP_MODE_REQUEST]
                                                           && !wake_i;
            end
            if (lock) begin
                clock_control_1_d[CC1_PLL_SELECT] = clock_control_1_q[CC1_PLL_SELECT];
            end
        end
        if ((stop_entry && main_mode) || main_stop_low_speed) begin
            clock_control_1_d[CC1_MAIN_DRIVE_HIGH] = 1'b1;
        end
        if (fixed_div8) begin
            clock_control_1_d[CC1_MAIN_DRIVE_HIGH] = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            clock_control_0_q <= RST_CLOCK_CONTROL_0;
            clock_control_1_q <= RST_CLOCK_CONTROL_1;
        end else begin
            clock_control_0_q <= clock_control_0_d;
            clock_control_1_q <= clock_control_1_d;
        end
    end

    // oscillation-stop detect control: the detect enable is frozen by the lock
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            osc_stop_detect_control_q <= RST_OSC_STOP_DETECT;
        end else if (wr_en && (paddr_i == ADDR_OSC_STOP_DETECT) && unlock) begin
            osc_stop_detect_control_q <= pwdata_i[7:0];
            if (lock) begin
                osc_stop_detect_control_q[OSD_DETECT_ENABLE] <= osc_stop_detect_control_q[OSD_DETECT_ENABLE];
            end
        end
    end

    // processor mode 2 has its own unlock bit; the clock change lock is sticky
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            processor_mode_2_q <= RST_PROCESSOR_MODE_2;
        end else if (wr_en && (paddr_i == ADDR_PROCESSOR_MODE_2)
                     && write_protect_register_q[WP_MODE_REG_WRITE_UNLOCK]) begin
            processor_mode_2_q <= pwdata_i[7:0];
            processor_mode_2_q[PM2_CLOCK_CHANGE_LOCK] <= lock || pwdata_i[PM2_CLOCK_CHANGE_LOCK];
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            write_protect_register_q <= RST_WRITE_PROTECT;
        end else if (wr_en && (paddr_i == ADDR_WRITE_PROTECT)) begin
            write_protect_register_q <= pwdata_i[7:0] & WP_WRITABLE_MASK;
        end
    end

    // pll control: frozen by the lock; ratio bits only change while the pll is off
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            pll_control_q <= RST_PLL_CONTROL;
        end else if (wr_en && (paddr_i == ADDR_PLL_CONTROL) && unlock && !lock) begin
            pll_control_q <= pwdata_i[7:0];
            if (pll_control_q[PLL_ON]) begin
                pll_control_q[2:0] <= pll_control_q[2:0];
            end
        end
    end

    // cpu clock source and divider selection
    always_comb begin
        if (clock_control_0_q[CC0_SUB_CLOCK_SELECT]) begin
            sel.src = SRC_SUB;
        end else if (osc_stop_detect_control_q[OSD_ONCHIP_OSC_SELECT]) begin
            sel.src = SRC_ONCHIP;
        end else if (clock_control_1_q[CC1_PLL_SELECT]) begin
            sel.src = SRC_PLL;
        end else begin
            sel.src = SRC_MAIN;
        end
        if (sel.src == SRC_SUB || sel.src == SRC_PLL) begin
            sel.half_count = HALF_DIV1;
        end else if (clock_control_0_q[CC0_DIV8_SELECT]) begin
            sel.half_count = HALF_DIV8;
        end else begin
            case (clock_control_1_q[CC1_DIV_RATIO_HIGH:CC1_DIV_RATIO_LOW])
                2'h0:    sel.half_count = HALF_DIV1;
                2'h1:    sel.half_count = HALF_DIV2;
                2'h2:    sel.half_count = HALF_DIV4;
                default: sel.half_count = HALF_DIV16;
            endcase
        end
        sel.halt = stop_mode_o;
    end

    glitchless_clk_div u_clk_div (
        .sys_clk_i  (sys_clk_i),
        .sys_rst_i  (sys_rst_i),
        .src_clks_i ({pll_clk_i, onchip_clk_i, sub_clk_i, main_clk_i}),
        .cfg        (sel),
        .cpu_clk_o  (cpu_clk_o)
    );

    // oscillator pin control
    assign stop_mode_o            = clock_control_1_q[CC1_STOP_MODE_REQUEST];
    assign main_osc_run_o         = !clock_control_0_q[CC0_MAIN_OSC_STOP] && !stop_mode_o;
    assign main_osc_output_high_o = clock_control_0_q[CC0_MAIN_OSC_STOP] || stop_mode_o;
    assign main_feedback_on_o     = !stop_mode_o;
    assign sub_osc_run_o          = clock_control_0_q[CC0_SUBOSC_PORT_SELECT] && !stop_mode_o;
    assign sub_feedback_on_o      = clock_control_0_q[CC0_SUBOSC_PORT_SELECT] && !stop_mode_o;
    assign sub_pins_hiz_o         = stop_mode_o;
    assign subosc_drive_high_o    = clock_control_0_q[CC0_SUBOSC_DRIVE_HIGH];
    assign main_drive_high_o      = clock_control_1_q[CC1_MAIN_DRIVE_HIGH];
    assign onchip_osc_run_o       = osc_stop_detect_control_q[OSD_ONCHIP_OSC_SELECT] || wdt_src;
    assign pll_on_o               = pll_control_q[PLL_ON];
    assign periph_stop_in_wait_o  = clock_control_0_q[CC0_PERIPH_STOP_IN_WAIT];
    assign osc_stop_detect_enable_o = osc_stop_detect_control_q[OSD_DETECT_ENABLE];

    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (sys_rst_i);

    a_locked_write_ignored: assert property (
        (wr_en && paddr_i == ADDR_CLOCK_CONTROL_0 && !unlock && !fixed_div8)
        |=> $stable(clock_control_0_q))
        else $error("clock control 0 changed by a write without unlock");

    a_sub_drive_forced: assert property (
        !clock_control_0_q[CC0_SUBOSC_PORT_SELECT] |-> subosc_drive_high_o)
        else $error("sub drive high not forced while sub pins are ports");

    a_main_stop_pins: assert property (
        (clock_control_0_q[CC0_MAIN_OSC_STOP] && !stop_mode_o) |-> main_osc_output_high_o && main_feedback_on_o)
        else $error("main oscillator stopped without output high and feedback on");

    a_stop_sets_div8: assert property (
        (stop_entry && !clock_control_0_q[CC0_SUB_CLOCK_SELECT]) |=> clock_control_0_q[CC0_DIV8_SELECT] && stop_mode_o)
        else $error("stop entry did not set divide-by-8");

    a_lock_freezes_bits: assert property (
        lock |=> $stable(clock_control_0_q[CC0_SUB_CLOCK_SELECT]) && $stable(clock_control_0_q[CC0_MAIN_OSC_STOP]))
        else $error("locked clock bits changed");

    a_div8_held_fixed: assert property (
        fixed_div8 |=> clock_control_0_q[CC0_DIV8_SELECT] && main_drive_high_o)
        else $error("divide-by-8 or main drive high not held while main stopped");

    a_stop_pin_state: assert property (
        $rose(stop_mode_o) |-> main_osc_output_high_o && !main_feedback_on_o && sub_pins_hiz_o && !sub_osc_run_o)
        else $error("stop mode pin state wrong");

    a_lock_sticky: assert property (
        lock |=> lock)
        else $error("clock change lock was cleared");

    a_wdt_blocks_stop: assert property (
        (wdt_src && !stop_mode_o) |=> !stop_mode_o)
        else $error("stop request accepted while watchdog uses on-chip source");

endmodule

`default_nettype wire

// >>> verif/osc_model.sv
`timescale 1ns/1ps
`default_nettype none

module osc_model (
    input  wire logic clk_i,
    input  wire logic main_run_i,
    input  wire logic sub_run_i,
    output var  logic main_clk_o,
    output var  logic sub_clk_o,
    output var  logic onchip_clk_o,
    output var  logic pll_clk_o
);
    logic [1:0] n_q = 2'h0;
    initial begin
        main_clk_o = 1'b0;
        sub_clk_o = 1'b0;
        pll_clk_o = 1'b0;
    end
    // a disabled main or sub oscillator leaves its line still, so a stalled cpu clock shows up
    always @(posedge clk_i) begin
        n_q <= n_q + 2'h1;
        onchip_clk_o <= n_q[0];
        pll_clk_o <= !pll_clk_o;
        if (main_run_i) main_clk_o <= !main_clk_o;
        if (sub_run_i && n_q == 2'h0) sub_clk_o <= !sub_clk_o;
    end
endmodule

`default_nettype wire

// >>> verif/clock_source_control_tb.sv
`timescale 1ns/1ps
`default_nettype none

module clock_source_control_tb
    import clock_source_control_pkg::*;
;
    logic        sys_clk_i, sys_rst_i, psel_i, penable_i, pwrite_i, wake_i, err, pready_o, pslverr_o;
    logic [7:0]  paddr_i;
    logic [31:0] pwdata_i, prdata_o, rv;
    logic        main_clk_i, sub_clk_i, onchip_clk_i, pll_clk_i, cpu_clk_o, stop_mode_o, main_osc_run_o;
    logic        main_osc_output_high_o, main_feedback_on_o, main_drive_high_o, sub_osc_run_o;
    logic        sub_feedback_on_o, sub_pins_hiz_o, subosc_drive_high_o, onchip_osc_run_o, pll_on_o;
    logic        periph_stop_in_wait_o, osc_stop_detect_enable_o;
    int          n_fail = 0, checked = 0, cyc = 0, tn = 0;
    realtime     t0;
    clock_source_control i_clock_source_control (.*);
    osc_model i_osc_model (.clk_i(sys_clk_i), .main_run_i(main_osc_run_o), .sub_run_i(sub_osc_run_o),
        .main_clk_o(main_clk_i), .sub_clk_o(sub_clk_i), .onchip_clk_o(onchip_clk_i), .pll_clk_o(pll_clk_i));
    initial begin
        sys_clk_i = 1'b0;
        forever #12.5 sys_clk_i = !sys_clk_i;
    end
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge sys_clk_i) begin
        cyc++;
        if (cyc == 2000) begin
            n_fail++;
            end_of_test();
        end
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checked++;
        if (s !== e) begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    // apb master: request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= {24'h000000, d};
        @(posedge sys_clk_i);
        penable_i <= 1'b1;
        do @(posedge sys_clk_i); while (pready_o !== 1'b1);
        rv = prdata_o;
        err = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        chk(rv, {24'h000000, e});
    endtask
    task automatic settle;
        @(posedge sys_clk_i);
        #1;
    endtask
    // cpu clock period in system cycles; main source transitions once per cycle
    task automatic per(input int e);
        // skip a cpu edge launched together with the write that set the ratio
        @(posedge sys_clk_i);
        @(posedge cpu_clk_o);
        t0 = $realtime;
        @(posedge cpu_clk_o);
        chk(32'(int'(($realtime - t0) / 25.0)), 32'(e));
    endtask
    task automatic done;
        tn++;
        $display("test %0d finished", tn);
    endtask
    initial begin
        {sys_rst_i, psel_i, penable_i, pwrite_i, wake_i, paddr_i, pwdata_i} = {5'h10, 8'h00, 32'h0};
        repeat (12) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        rd(ADDR_CLOCK_CONTROL_0, RST_CLOCK_CONTROL_0);
        rd(ADDR_CLOCK_CONTROL_1, RST_CLOCK_CONTROL_1);
        chk({30'h0, sub_osc_run_o, sub_feedback_on_o}, 32'h0);
        per(16);
        done();
        apb(1'b1, ADDR_CLOCK_CONTROL_0, 8'h00);
        rd(ADDR_CLOCK_CONTROL_0, 8'h48);
        apb(1'b1, ADDR_WRITE_PROTECT, 8'h03);
        apb(1'b1, ADDR_CLOCK_CONTROL_0, 8'h00);
        rd(ADDR_CLOCK_CONTROL_0, 8'h08);
        apb(1'b1, ADDR_CLOCK_CONTROL_0, 8'h10);
        repeat (8) @(posedge sys_clk_i);
        apb(1'b1, ADDR_CLOCK_CONTROL_0, 8'h90);
        apb(1'b1, ADDR_OSC_STOP_DETECT, 8'h00);
        apb(1'b1, ADDR_CLOCK_CONTROL_0, 8'hB0);
        apb(1'b1, ADDR_CLOCK_CONTROL_1, 8'h00);
        rd(ADDR_CLOCK_CONTROL_0, 8'hF0);
        rd(ADDR_CLOCK_CONTROL_1, 8'h20);
        chk({30'h0, main_osc_output_high_o, main_feedback_on_o}, 32'h3);
        apb(1'b0, 8'h1C, 8'h00);
        chk({31'h0, err}, 32'h1);
        done();
        apb(1'b1, ADDR_CLOCK_CONTROL_0, 8'hD0);
        repeat (8) @(posedge sys_clk_i);
        apb(1'b1, ADDR_OSC_STOP_DETECT, 8'h02);
        apb(1'b1, ADDR_CLOCK_CONTROL_0, 8'h50);
        apb(1'b1, ADDR_CLOCK_CONTROL_1, 8'h60);
        chk({31'h0, onchip_osc_run_o}, 32'h1);
        per(16);
        apb(1'b1, ADDR_OSC_STOP_DETECT, 8'h00);
        apb(1'b1, ADDR_CLOCK_CONTROL_0, 8'h10);
        per(4);
        apb(1'b1, ADDR_PLL_CONTROL, 8'h82);
        settle();
        chk({31'h0, pll_on_o}, 32'h1);
        repeat (8) @(posedge sys_clk_i);
        apb(1'b1, ADDR_CLOCK_CONTROL_1, 8'h62);
        per(2);
        apb(1'b1, ADDR_CLOCK_CONTROL_1, 8'h60);
        done();
        apb(1'b1, ADDR_CLOCK_CONTROL_1, 8'h41);
        settle();
        chk({28'h0, stop_mode_o, sub_pins_hiz_o, main_osc_output_high_o, main_feedback_on_o}, 32'hE);
        chk({30'h0, main_drive_high_o, subosc_drive_high_o}, 32'h3);
        rd(ADDR_CLOCK_CONTROL_0, 8'h58);
        rd(ADDR_CLOCK_CONTROL_1, 8'h61);
        wake_i <= 1'b1;
        @(posedge sys_clk_i);
        wake_i <= 1'b0;
        done();
        apb(1'b1, ADDR_PROCESSOR_MODE_2, 8'h04);
        apb(1'b1, ADDR_CLOCK_CONTROL_1, 8'h41);
        settle();
        chk({31'h0, stop_mode_o}, 32'h0);
        apb(1'b1, ADDR_PROCESSOR_MODE_2, 8'h02);
        apb(1'b1, ADDR_PROCESSOR_MODE_2, 8'h00);
        rd(ADDR_PROCESSOR_MODE_2, 8'h02);
        apb(1'b1, ADDR_CLOCK_CONTROL_0, 8'hA4);
        rd(ADDR_CLOCK_CONTROL_0, 8'h08);
        apb(1'b1, ADDR_OSC_STOP_DETECT, 8'h01);
        settle();
        chk({30'h0, osc_stop_detect_enable_o, periph_stop_in_wait_o}, 32'h0);
        apb(1'b1, ADDR_CLOCK_CONTROL_1, 8'h03);
        rd(ADDR_CLOCK_CONTROL_1, 8'h00);
        done();
        end_of_test();
    end
endmodule

`default_nettype wire
